/* sfp_pin_front.sv */
// Purpose: pin front end of a serial flash device: select, lanes, pause,
//          status write protection
// Assumes: sck and all pins asynchronous, sck well below sys_clk_in / 4
// Notes:   received bytes leave through a fifo, sent bytes come from a register
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "sfp_regs.svh"
module sfp_pin_front #(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic       sys_clk_in,
    input  wire logic       nrst_in,
    input  wire logic       chip_enable_n_in,
    input  wire logic       sck_in,
    input  wire logic [3:0] data_lane_in,
    output logic      [3:0] data_lane_out,
    output logic      [3:0] data_lane_oe_n_out,
    output logic            standby_out,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic      [7:0] reg_rdata_out,
    output logic            rx_valid_out,
    output logic      [7:0] rx_data_out,
    input  wire logic       rx_ready_in
);
    import sfp_pkg::*;

    default clocking dcb @(posedge sys_clk_in);
    endclocking
    default disable iff (!nrst_in);

    // ****************************************
    // declarations
    // ****************************************
    logic [5:0]  meta_q;
    logic [5:0]  sync_q;
    logic        sck_prev_q;
    logic        ce_prev_q;
    logic        ce_s;
    logic        sck_s;
    logic [3:0]  lane_s;
    logic        sck_rise;
    logic        sck_fall;
    logic        sel_edge;
    sfp_phase_t  ph_q;
    logic [2:0]  ctrl_q;
    logic [5:0]  sr_q;
    logic [7:0]  tx_data_q;
    logic        qpi_q;
    logic        ovr_q;
    logic        quad_ok;
    logic        pause_act;
    logic        wp_act;
    logic        sr_locked;
    sfp_width_t  width;
    logic [2:0]  step;
    logic        active;
    logic        txen;
    logic        rx_stb;
    logic        tx_stb;
    logic [7:0]  rx_sh_q;
    logic [7:0]  rx_next;
    logic [2:0]  rx_cnt_q;
    logic        rx_done;
    logic        pend_q;
    logic [7:0]  pend_data_q;
    logic        fifo_ready;
    logic [7:0]  tx_sh_q;
    logic [7:0]  tx_cur;
    logic [2:0]  tx_cnt_q;
    logic [3:0]  lane_out_q;
    logic [3:0]  lane_mask;
    logic        drive;
    logic        wr_sr;
    logic        wr_cmd;
    logic [7:0]  rd_mux;
    logic [7:0]  rdata_q;

    function automatic sfp_width_t width_of(input logic [1:0] code, input logic quad, input logic quad_command_mode);
        width_of = SFP_W1;
        if (quad_command_mode || (quad && code == `SFP_WCODE_QUAD)) begin
            width_of = SFP_W4;
        end else if (code == `SFP_WCODE_DUAL) begin
            width_of = SFP_W2;
        end
    endfunction

    // ****************************************
    // pin synchronisers and edge finding
    // ****************************************
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            meta_q <= `SFP_SYNC_RST;
            sync_q <= `SFP_SYNC_RST;
        end else begin
            meta_q <= {sck_in, chip_enable_n_in, data_lane_in};
            sync_q <= meta_q;
        end
    end

    // prev flops reset low so a select held through reset gives no false edge
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            sck_prev_q <= 1'b0;
            ce_prev_q  <= 1'b0;
        end else begin
            sck_prev_q <= sync_q[5];
            ce_prev_q  <= sync_q[4];
        end
    end

    assign sck_s    = sync_q[5];
    assign ce_s     = sync_q[4];
    assign lane_s   = sync_q[3:0];
    assign sck_rise = sck_s && !sck_prev_q;
    assign sck_fall = !sck_s && sck_prev_q;
    assign sel_edge = ce_prev_q && !ce_s;

    // ****************************************
    // pin roles and protection
    // ****************************************
    assign quad_ok   = sr_q[`SFP_SR_QE] || qpi_q;
    assign pause_act = !ce_s && !quad_ok && !lane_s[3];
    assign wp_act    = !quad_ok && !lane_s[2];
    assign sr_locked = sr_q[`SFP_SR_STATUS_WRITE_DISABLE] && wp_act;
    assign width     = width_of(ctrl_q[1:0], sr_q[`SFP_SR_QE], qpi_q);
    assign step      = (width == SFP_W1) ? 3'h1 : (width == SFP_W2) ? 3'h2 : 3'h4;
    assign txen      = ctrl_q[`SFP_CTRL_TXEN];

    // ****************************************
    // select state
    // ****************************************
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            ph_q <= SFP_PH_OFF;
        end else begin
            case (ph_q)
                SFP_PH_OFF: begin
                    if (sel_edge) begin
                        ph_q <= SFP_PH_ACT;
                    end
                end
                SFP_PH_ACT: begin
                    if (ce_s) begin
                        ph_q <= SFP_PH_OFF;
                    end else if (pause_act) begin
                        ph_q <= SFP_PH_PAUSE;
                    end
                end
                SFP_PH_PAUSE: begin
                    if (ce_s) begin
                        ph_q <= SFP_PH_OFF;
                    end else if (!pause_act) begin
                        ph_q <= SFP_PH_ACT;
                    end
                end
                default: begin
                    ph_q <= SFP_PH_OFF;
                end
            endcase
        end
    end

    assign standby_out = ph_q == SFP_PH_OFF;
    assign active      = ph_q == SFP_PH_ACT && !ce_s && !pause_act;
    assign rx_stb      = active && sck_rise && !txen;
    assign tx_stb      = active && sck_fall && txen;

    // ****************************************
    // receive path
    // ****************************************
    always_comb begin
        case (width)
            SFP_W1:  rx_next = {rx_sh_q[6:0], lane_s[0]};
            SFP_W2:  rx_next = {rx_sh_q[5:0], lane_s[1:0]};
            default: rx_next = {rx_sh_q[3:0], lane_s};
        endcase
    end

    assign rx_done = rx_stb && (3'(rx_cnt_q + step) == 3'h0);

    // counters survive a pause, only deselect restarts the byte
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            rx_sh_q  <= 8'h00;
            rx_cnt_q <= 3'h0;
        end else if (ph_q == SFP_PH_OFF) begin
            rx_cnt_q <= 3'h0;
        end else if (rx_stb) begin
            rx_sh_q  <= rx_next;
            rx_cnt_q <= 3'(rx_cnt_q + step);
        end
    end

    // one byte of slack; sck cannot be stalled, so a full fifo is an overrun
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            pend_q      <= 1'b0;
            pend_data_q <= 8'h00;
        end else if (rx_done && (!pend_q || fifo_ready)) begin
            pend_q      <= 1'b1;
            pend_data_q <= rx_next;
        end else if (pend_q && fifo_ready) begin
            pend_q <= 1'b0;
        end
    end

    // set wins over the clear
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            ovr_q <= 1'b0;
        end else if (rx_done && pend_q && !fifo_ready) begin
            ovr_q <= 1'b1;
        end else if (wr_cmd && reg_wdata_in[`SFP_CMD_CLROVR]) begin
            ovr_q <= 1'b0;
        end
    end

    sfp_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .sys_clk_in    (sys_clk_in),
        .nrst_in       (nrst_in),
        .in_valid_in   (pend_q),
        .in_ready_out  (fifo_ready),
        .in_data_in    (pend_data_q),
        .out_valid_out (rx_valid_out),
        .out_ready_in  (rx_ready_in),
        .out_data_out  (rx_data_out)
    );

    // ****************************************
    // transmit path
    // ****************************************
    assign tx_cur = (tx_cnt_q == 3'h0) ? tx_data_q : tx_sh_q;

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            tx_sh_q    <= 8'h00;
            tx_cnt_q   <= 3'h0;
            lane_out_q <= 4'h0;
        end else if (ph_q == SFP_PH_OFF) begin
            tx_cnt_q <= 3'h0;
        end else if (tx_stb) begin
            case (width)
                SFP_W1:  lane_out_q <= {2'b00, tx_cur[7], 1'b0};
                SFP_W2:  lane_out_q <= {2'b00, tx_cur[7:6]};
                default: lane_out_q <= tx_cur[7:4];
            endcase
            tx_sh_q  <= 8'(tx_cur << step);
            tx_cnt_q <= 3'(tx_cnt_q + step);
        end
    end

    assign lane_mask = (width == SFP_W1) ? `SFP_MASK_W1 : (width == SFP_W2) ? `SFP_MASK_W2 : `SFP_MASK_W4;
    assign drive     = ph_q != SFP_PH_OFF && !ce_s && !pause_act && txen;
    assign data_lane_oe_n_out = ~(lane_mask & {4{drive}});
    assign data_lane_out      = lane_out_q;

    // ****************************************
    // register port
    // ****************************************
    assign wr_sr  = reg_wr_in && reg_addr_in == `SFP_OFS_SR;
    assign wr_cmd = reg_wr_in && reg_addr_in == `SFP_OFS_CMD;

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            ctrl_q    <= `SFP_CTRL_RST;
            tx_data_q <= `SFP_TXD_RST;
        end else if (reg_wr_in && reg_addr_in == `SFP_OFS_CTRL) begin
            ctrl_q <= reg_wdata_in[2:0];
        end else if (reg_wr_in && reg_addr_in == `SFP_OFS_TXD) begin
            tx_data_q <= reg_wdata_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            sr_q <= `SFP_SR_RST;
        end else if (wr_sr && !sr_locked) begin
            sr_q <= reg_wdata_in[5:0];
        end
    end

    // exit beats enter when both are written together
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            qpi_q <= 1'b0;
        end else if (wr_cmd && reg_wdata_in[`SFP_CMD_QPI_EX]) begin
            qpi_q <= 1'b0;
        end else if (wr_cmd && reg_wdata_in[`SFP_CMD_QPI_EN]) begin
            qpi_q <= 1'b1;
        end
    end

    always_comb begin
        rd_mux = 8'h00;
        case (reg_addr_in)
            `SFP_OFS_CTRL: rd_mux = {5'h00, ctrl_q};
            `SFP_OFS_SR:   rd_mux = {2'h0, sr_q};
            `SFP_OFS_TXD:  rd_mux = tx_data_q;
            `SFP_OFS_STAT: rd_mux = {2'h0, sr_locked, wp_act, ovr_q, qpi_q, ph_q == SFP_PH_PAUSE, standby_out};
            default:       rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd_in ? rd_mux : 8'h00;
        end
    end

    assign reg_rdata_out = rdata_q;

    // ****************************************
    // checks
    // ****************************************
    chk_desel_float: assert property (ce_s |-> &data_lane_oe_n_out)
        else $error("lane driven while deselected");
    chk_standby_entry: assert property ($rose(ce_s) |=> standby_out)
        else $error("no standby after deselect");
    chk_select_wake: assert property (sel_edge |=> !standby_out)
        else $error("select edge did not wake");
    chk_first_edge: assert property (standby_out && !sel_edge |=> standby_out)
        else $error("left standby without select edge");
    chk_rx_desel: assert property (ce_s |-> !rx_stb && !rx_done)
        else $error("input taken while deselected");
    chk_rx_rise: assert property (rx_stb |-> sck_s && !sck_prev_q)
        else $error("sample off the rising edge");
    chk_tx_fall: assert property ($changed(lane_out_q) |-> $past(sck_fall))
        else $error("output changed off the falling edge");
    chk_quad_lanes: assert property (drive && width == SFP_W4 |-> data_lane_oe_n_out == 4'h0)
        else $error("quad read not on all lanes");
    chk_sr_lock: assert property (wr_sr && sr_locked |=> $stable(sr_q))
        else $error("locked status changed");
    chk_sr_open: assert property (wr_sr && !sr_q[`SFP_SR_STATUS_WRITE_DISABLE] |=> sr_q == $past(reg_wdata_in[5:0]))
        else $error("open status write lost");
    chk_qe_nowp: assert property (sr_q[`SFP_SR_QE] |-> !wp_act && !sr_locked)
        else $error("protect pin active with quad enable");
    chk_pause_float: assert property (pause_act |-> data_lane_oe_n_out[1] && !rx_stb && !tx_stb)
        else $error("activity during pause");
    chk_pause_keep: assert property (ph_q == SFP_PH_PAUSE |=> $stable(rx_cnt_q) && $stable(tx_cnt_q))
        else $error("pause disturbed the sequence");
    chk_qpi_width: assert property (qpi_q |-> width == SFP_W4)
        else $error("command mode not on four lanes");
    chk_idle_float: assert property (!txen |-> &data_lane_oe_n_out)
        else $error("lane driven outside data-out phase");

    cov_rx_byte: cover property (rx_done ##[1:4] rx_valid_out);
    cov_tx_quad: cover property (tx_stb && width == SFP_W4);
    cov_locked_wr: cover property (wr_sr && sr_locked);
    cov_pause: cover property (ph_q == SFP_PH_PAUSE ##1 ph_q == SFP_PH_ACT);

endmodule

/* sfp_regs.svh */
// Purpose: register offsets, field positions and reset values of the
//          serial flash pin front end
// Assumes: 8-bit register port, one byte per register
// Notes:   definitions only
`ifndef SFP_REGS_SVH
`define SFP_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define SFP_OFS_CTRL   8'h00
`define SFP_OFS_SR     8'h01
`define SFP_OFS_TXD    8'h02
`define SFP_OFS_STAT   8'h03
`define SFP_OFS_CMD    8'h04

// ****************************************
// field positions
// ****************************************
`define SFP_CTRL_TXEN  2
`define SFP_SR_QE      4
`define SFP_SR_STATUS_WRITE_DISABLE    5
`define SFP_ST_STANDBY 0
`define SFP_ST_PAUSE   1
`define SFP_ST_QPI     2
`define SFP_ST_OVRUN   3
`define SFP_ST_WPACT   4
`define SFP_ST_LOCKED  5
`define SFP_CMD_QPI_EN 0
`define SFP_CMD_QPI_EX 1
`define SFP_CMD_CLROVR 2

// ****************************************
// codes and reset values
// ****************************************
`define SFP_WCODE_DUAL 2'h1
`define SFP_WCODE_QUAD 2'h2
`define SFP_CTRL_RST   3'h0
`define SFP_SR_RST     6'h00
`define SFP_TXD_RST    8'h00
`define SFP_SYNC_RST   6'h00
`define SFP_MASK_W1    4'h2
`define SFP_MASK_W2    4'h3
`define SFP_MASK_W4    4'hf

`endif

/* sfp_pkg.sv */
// Purpose: shared types of the serial flash pin front end
// Assumes: nothing
// Notes:   constants live in sfp_regs.svh
package sfp_pkg;

    typedef enum logic [1:0] {
        SFP_W1,
        SFP_W2,
        SFP_W4
    } sfp_width_t;

    typedef enum logic [1:0] {
        SFP_PH_OFF,
        SFP_PH_ACT,
        SFP_PH_PAUSE
    } sfp_phase_t;

endpackage

/* sfp_fifo.sv */
// Purpose: small synchronous fifo for received bytes
// Assumes: single clock, DEPTH of two or more
// Notes:   valid/ready on both sides
`timescale 1ns/1ps
module sfp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk_in,
    input  wire logic             nrst_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready_out  = cnt_q != (AW+1)'(DEPTH);
    assign out_valid_out = cnt_q != '0;
    assign out_data_out  = mem_q[rd_ptr_q];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    // data store needs no reset, only the pointers and the count do
    always_ff @(posedge sys_clk_in) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : AW'(wr_ptr_q + 1'b1);
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : AW'(rd_ptr_q + 1'b1);
            end
            if (push && !pop) begin
                cnt_q <= (AW+1)'(cnt_q + 1'b1);
            end else if (pop && !push) begin
                cnt_q <= (AW+1)'(cnt_q - 1'b1);
            end
        end
    end

    chk_fifo_bound: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count above depth");

endmodule

/* sfp_spi_master.sv */
// Purpose: spi master stand-in that drives the flash pins
// Assumes: sck half period of 4 sys clocks (160 ns period)
// Notes:   lanes it leaves undriven are resolved by the bench
`timescale 1ns/1ps
module sfp_spi_master (
    input  wire logic       sys_clk_in,
    input  wire logic [3:0] lane_in,
    output logic            ce_n_out,
    output logic            sck_out,
    output logic      [3:0] mdrv_out,
    output logic      [3:0] men_out
);
    logic idle_q;

    // select held low from time zero, so no select edge yet
    initial begin
        ce_n_out = 1'b0;
        sck_out  = 1'b0;
        mdrv_out = 4'hc;
        men_out  = 4'hd;
        idle_q   = 1'b0;
    end

    // ****************************************
    // pin tasks
    // ****************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask

    task automatic sel(input logic v, input logic mode3);
        cyc(1);
        idle_q = mode3;
        sck_out <= mode3;
        cyc(4);
        ce_n_out <= v;
        cyc(6);
    endtask

    // pins = {pause, write protect} while those lanes are not data
    task automatic cfg(input logic [3:0] en, input logic [1:0] pins);
        cyc(1);
        men_out       <= en;
        mdrv_out[3:2] <= pins;
    endtask

    // sample late in the high phase: device output lags its synchronisers
    task automatic shift(input int w, input logic [7:0] tx, output logic [7:0] rx);
        logic [3:0] nxt;
        rx = 8'h00;
        for (int k = 0; k < 8 / w; k++) begin
            cyc(1);
            nxt = mdrv_out;
            for (int i = 0; i < w; i++) begin
                nxt[i] = tx[8 - (k + 1) * w + i];
            end
            sck_out  <= 1'b0;
            mdrv_out <= nxt;
            cyc(4);
            sck_out <= 1'b1;
            cyc(3);
            for (int i = 0; i < w; i++) begin
                rx[8 - (k + 1) * w + i] = lane_in[(w == 1) ? 1 : i];
            end
        end
        if (!idle_q) begin
            cyc(1);
            sck_out <= 1'b0;
        end
    endtask
endmodule

/* tb_serial_flash_pin_interface.sv */
// Purpose: self-checking bench of the serial flash pin front end
// Assumes: 50 MHz sys clock, sck of 160 ns from the master model
// Notes:   lanes nobody drives show the inverse of their last level
`timescale 1ns/1ps
`include "sfp_regs.svh"
module tb_serial_flash_pin_interface;
    // ****************************************
    // signals
    // ****************************************
    logic       clk;
    logic       nrst;
    logic       ce_n;
    logic       sck;
    logic       wr;
    logic       rd;
    logic       rx_ready;
    logic       rx_valid;
    logic       standby;
    logic [3:0] lane_in;
    logic [3:0] lane_out;
    logic [3:0] oe_n;
    logic [3:0] mdrv;
    logic [3:0] men;
    logic [3:0] last_q;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] rx_data;
    logic [7:0] got;
    int         failures = 0;
    int         samples_checked = 0;

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            lane_in[i] = !oe_n[i] ? lane_out[i] : (men[i] ? mdrv[i] : ~last_q[i]);
        end
    end

    always_ff @(posedge clk) last_q <= lane_in;

    sfp_spi_master master (
        .sys_clk_in (clk),
        .lane_in    (lane_in),
        .ce_n_out   (ce_n),
        .sck_out    (sck),
        .mdrv_out   (mdrv),
        .men_out    (men)
    );

    sfp_pin_front #(
        .FIFO_DEPTH(8)
    ) dut (
        .sys_clk_in         (clk),
        .nrst_in            (nrst),
        .chip_enable_n_in   (ce_n),
        .sck_in             (sck),
        .data_lane_in       (lane_in),
        .data_lane_out      (lane_out),
        .data_lane_oe_n_out (oe_n),
        .standby_out        (standby),
        .reg_addr_in        (addr),
        .reg_wdata_in       (wdata),
        .reg_wr_in          (wr),
        .reg_rd_in          (rd),
        .reg_rdata_out      (rdata),
        .rx_valid_out       (rx_valid),
        .rx_data_out        (rx_data),
        .rx_ready_in        (rx_ready)
    );

    // ****************************************
    // tasks
    // ****************************************
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] msk, input logic [7:0] e, input string m);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata & msk, e, m);
    endtask

    task automatic pop(input logic [7:0] e, input string m);
        int n;
        n = 0;
        #1;
        while (rx_valid !== 1'b1 && n < 200) begin
            cyc(1);
            n++;
        end
        chk({7'h00, rx_valid}, 8'h01, m);
        chk(rx_data, e, m);
        @(posedge clk);
        rx_ready <= 1'b1;
        @(posedge clk);
        rx_ready <= 1'b0;
    endtask

    task automatic no_rx(input string m);
        cyc(12);
        chk({7'h00, rx_valid}, 8'h00, m);
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        tally_and_finish;
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        nrst     = 1'b0;
        addr     = 8'h00;
        wdata    = 8'h00;
        wr       = 1'b0;
        rd       = 1'b0;
        rx_ready = 1'b0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        cyc(2);
        chk({4'h0, oe_n}, 8'h0f, "float at reset");
        rd_chk(`SFP_OFS_SR, 8'hff, 8'h00, "sr reset");
        rd_chk(`SFP_OFS_STAT, 8'h2e, 8'h00, "stat reset");
        wr_reg(8'h07, 8'hff);
        rd_chk(8'h07, 8'hff, 8'h00, "unmapped");
        master.shift(1, 8'h5a, got);
        no_rx("no select edge");
        master.sel(1'b1, 1'b0);
        chk({7'h00, standby}, 8'h01, "standby");
        chk({4'h0, oe_n}, 8'h0f, "float");
        master.shift(1, 8'h33, got);
        no_rx("deselected");
        master.sel(1'b0, 1'b0);
        chk({7'h00, standby}, 8'h00, "selected");
        master.shift(1, 8'hc6, got);
        pop(8'hc6, "single mode 0");
        master.sel(1'b1, 1'b1);
        master.sel(1'b0, 1'b1);
        master.shift(1, 8'h81, got);
        pop(8'h81, "single mode 3");
        wr_reg(`SFP_OFS_CTRL, 8'h01);
        master.cfg(4'hf, 2'b11);
        master.shift(2, 8'h6b, got);
        pop(8'h6b, "dual");
        $display("test receive done");
        wr_reg(`SFP_OFS_CTRL, 8'h04);
        wr_reg(`SFP_OFS_TXD, 8'h3c);
        master.cfg(4'hd, 2'b11);
        master.shift(1, 8'h00, got);
        chk(got, 8'h3c, "tx single");
        chk({4'h0, oe_n}, 8'h0d, "drive lane 1 only");
        master.cfg(4'hd, 2'b01);
        cyc(6);
        chk({4'h0, oe_n}, 8'h0f, "pause floats");
        rd_chk(`SFP_OFS_STAT, 8'h02, 8'h02, "paused");
        master.cfg(4'hd, 2'b11);
        master.sel(1'b1, 1'b1);
        chk({4'h0, oe_n}, 8'h0f, "deselect floats");
        wr_reg(`SFP_OFS_CTRL, 8'h00);
        master.sel(1'b0, 1'b0);
        master.cfg(4'hd, 2'b01);
        master.shift(1, 8'h11, got);
        no_rx("paused rx");
        master.cfg(4'hd, 2'b11);
        master.shift(1, 8'h22, got);
        pop(8'h22, "resumed");
        $display("test transmit and pause done");
        wr_reg(`SFP_OFS_SR, 8'h20);
        master.cfg(4'hd, 2'b10);
        cyc(6);
        wr_reg(`SFP_OFS_SR, 8'h0f);
        rd_chk(`SFP_OFS_SR, 8'hff, 8'h20, "locked");
        rd_chk(`SFP_OFS_STAT, 8'h30, 8'h30, "lock flag");
        master.cfg(4'hd, 2'b11);
        cyc(6);
        wr_reg(`SFP_OFS_SR, 8'h2f);
        rd_chk(`SFP_OFS_SR, 8'hff, 8'h2f, "protect high");
        wr_reg(`SFP_OFS_SR, 8'h00);
        master.cfg(4'hd, 2'b10);
        cyc(6);
        wr_reg(`SFP_OFS_SR, 8'h0f);
        rd_chk(`SFP_OFS_SR, 8'hff, 8'h0f, "disable clear");
        wr_reg(`SFP_OFS_SR, 8'h30);
        wr_reg(`SFP_OFS_SR, 8'h3a);
        rd_chk(`SFP_OFS_SR, 8'hff, 8'h3a, "quad enable frees pin");
        rd_chk(`SFP_OFS_STAT, 8'h30, 8'h00, "protect pin freed");
        wr_reg(`SFP_OFS_SR, 8'h00);
        $display("test protection done");
        wr_reg(`SFP_OFS_CMD, 8'h01);
        rd_chk(`SFP_OFS_STAT, 8'h04, 8'h04, "quad mode on");
        wr_reg(`SFP_OFS_CTRL, 8'h02);
        master.cfg(4'hf, 2'b11);
        master.shift(4, 8'h9e, got);
        pop(8'h9e, "quad");
        @(posedge clk);
        nrst <= 1'b0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(`SFP_OFS_STAT, 8'h04, 8'h00, "reset leaves quad");
        rd_chk(`SFP_OFS_CTRL, 8'hff, 8'h00, "ctrl reset");
        wr_reg(`SFP_OFS_CMD, 8'h01);
        rd_chk(`SFP_OFS_STAT, 8'h04, 8'h04, "quad mode again");
        wr_reg(`SFP_OFS_CMD, 8'h02);
        rd_chk(`SFP_OFS_STAT, 8'h04, 8'h00, "quad mode exit");
        wr_reg(`SFP_OFS_CMD, 8'h01);
        wr_reg(`SFP_OFS_CMD, 8'h03);
        rd_chk(`SFP_OFS_STAT, 8'h04, 8'h00, "exit beats enter");
        $display("test quad done");
        master.cfg(4'hd, 2'b11);
        master.sel(1'b1, 1'b0);
        master.sel(1'b0, 1'b0);
        for (int i = 0; i < 10; i++) begin
            master.shift(1, 8'(i + 64), got);
        end
        rd_chk(`SFP_OFS_STAT, 8'h08, 8'h08, "overrun");
        for (int i = 0; i < 8; i++) begin
            pop(8'(i + 64), "fifo order");
        end
        @(posedge clk);
        rx_ready <= 1'b1;
        repeat (8) @(posedge clk);
        rx_ready <= 1'b0;
        cyc(2);
        chk({7'h00, rx_valid}, 8'h00, "drained");
        wr_reg(`SFP_OFS_CMD, 8'h04);
        rd_chk(`SFP_OFS_STAT, 8'h08, 8'h00, "overrun cleared");
        $display("test fifo done");
        tally_and_finish;
    end
endmodule
